// ---- adcrc_axil.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "adcrc_params.svh"
module adcrc_axil
  import adcrc_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  input  wire logic [`ADCRC_AW-1:0] awaddr_i,
  input  wire logic                 awvalid_i,
  output logic                      awready_o,
  input  wire logic [31:0]          wdata_i,
  input  wire logic [3:0]           wstrb_i,
  input  wire logic                 wvalid_i,
  output logic                      wready_o,
  output logic [1:0]                bresp_o,
  output logic                      bvalid_o,
  input  wire logic                 bready_i,
  input  wire logic [`ADCRC_AW-1:0] araddr_i,
  input  wire logic                 arvalid_i,
  output logic                      arready_o,
  output logic [31:0]               rdata_o,
  output logic [1:0]                rresp_o,
  output logic                      rvalid_o,
  input  wire logic                 rready_i,
  adcrc_if.slv                      rif
);
  logic                 aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic                 awr_q, awr_d, wr_q, wr_d, arr_q, arr_d;
  logic [`ADCRC_AW-1:0] ad_q, ad_d;
  logic [15:0]          wd_q, wd_d;
  logic [1:0]           ws_q, ws_d, br_q, br_d, rr_q, rr_d;
  logic [31:0]          rd_q, rd_d;
  logic                 rhit;

  assign rif.wr_idx  = ad_q[`ADCRC_AW-1:2];
  assign rif.wr_data = wd_q;
  assign rif.wr_strb = ws_q;
  assign rif.rd_idx  = araddr_i[`ADCRC_AW-1:2];
  assign rhit        = adcrc_hit(araddr_i);

  // channel handshakes, write commit once address and data are both held
  always_comb begin
    aw_d = aw_q; ad_d = ad_q; w_d = w_q; wd_d = wd_q; ws_d = ws_q;
    b_d = b_q; br_d = br_q; r_d = r_q; rd_d = rd_q; rr_d = rr_q;
    rif.wr_en = 1'b0;
    rif.rd_en = 1'b0;
    if (awvalid_i && awr_q) begin
      aw_d = 1'b1;
      ad_d = awaddr_i;
    end
    if (wvalid_i && wr_q) begin
      w_d  = 1'b1;
      wd_d = wdata_i[15:0];
      ws_d = wstrb_i[1:0];
    end
    if (b_q && bready_i) begin
      b_d = 1'b0;
    end
    if (aw_q && w_q && !b_q) begin
      rif.wr_en = adcrc_hit(ad_q);
      aw_d = 1'b0;
      w_d  = 1'b0;
      b_d  = 1'b1;
      br_d = adcrc_hit(ad_q) ? `ADCRC_RESP_OK : `ADCRC_RESP_ERR;
    end
    if (r_q && rready_i) begin
      r_d = 1'b0;
    end
    if (arvalid_i && arr_q) begin
      rif.rd_en = rhit;
      r_d  = 1'b1;
      rd_d = rhit ? {16'h0000, rif.rd_data} : 32'h0000_0000;
      rr_d = rhit ? `ADCRC_RESP_OK : `ADCRC_RESP_ERR;
    end
    awr_d = !aw_d && !b_d;
    wr_d  = !w_d && !b_d;
    arr_d = !r_d;
  end

  // register bus state
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b0; r_q <= 1'b0;
      awr_q <= 1'b0; wr_q <= 1'b0; arr_q <= 1'b0;
      ad_q <= '0; wd_q <= 16'h0000; ws_q <= 2'h0;
      br_q <= `ADCRC_RESP_OK; rr_q <= `ADCRC_RESP_OK; rd_q <= 32'h0000_0000;
    end else begin
      aw_q <= aw_d; w_q <= w_d; b_q <= b_d; r_q <= r_d;
      awr_q <= awr_d; wr_q <= wr_d; arr_q <= arr_d;
      ad_q <= ad_d; wd_q <= wd_d; ws_q <= ws_d;
      br_q <= br_d; rr_q <= rr_d; rd_q <= rd_d;
    end
  end

  assign awready_o = awr_q;
  assign wready_o  = wr_q;
  assign bvalid_o  = b_q;
  assign bresp_o   = br_q;
  assign arready_o = arr_q;
  assign rvalid_o  = r_q;
  assign rdata_o   = rd_q;
  assign rresp_o   = rr_q;
endmodule
`default_nettype wire

// ---- adcrc_clkdiv.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "adcrc_params.svh"
module adcrc_clkdiv
  import adcrc_pkg::*;
#(
  parameter int CW = 15
) (
  input  wire logic clk_i,
  input  wire logic srst_i,
  adcrc_if.div      dif
);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] mask;
  logic          tick_q;
  logic          tick_d;

  // ************************************
  // ratio mask: code n keeps bits n..0
  // ************************************
  genvar i;
  for (i = 0; i < CW; i++) begin : g_mask
    assign mask[i] = (i <= int'(dif.ratio));
  end

  // free-running counter, one tick every 2^(code+1) cycles
  always_comb begin
    cnt_d  = cnt_q + {{(CW-1){1'b0}}, 1'b1};
    tick_d = (dif.ratio != `ADCRC_RATIO_RSV) && (&(cnt_q | ~mask));
    if (tick_d) begin
      cnt_d = '0;
    end
    if (dif.restart) begin
      cnt_d  = '0;
      tick_d = 1'b0;
    end
  end

  // register counter and tick
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign dif.tick = tick_q;

  // at divide-by-2 the tick comes every second cycle
  property p_div2;
    @(posedge clk_i) disable iff (srst_i)
      (tick_q && dif.ratio == 4'h0 && !dif.restart) ##1 (dif.ratio == 4'h0 && !dif.restart)
      |=> tick_q;
  endproperty
  a_div2: assert property (p_div2) else $error("divide-by-2 tick missing");

  // a restart suppresses the tick and clears the count
  property p_restart;
    @(posedge clk_i) disable iff (srst_i)
      dif.restart |=> (!tick_q && cnt_q == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("divider not restarted");
endmodule
`default_nettype wire

// ---- adcrc_core_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// stand-in for the analog core: converts one channel every few conversion clock ticks
module adcrc_core_model #(
  parameter int NCH = 2
) (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic run_i,
  input  wire logic start_i,
  input  wire logic tick_i,
  input  wire logic slow_i,
  output logic      done_o,
  output logic      last_o
);
  int tk;
  int ch;

  // channel sequencer, restarted by every accepted trigger
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    last_o <= 1'b0;
    if (srst_i || start_i || !run_i) begin
      tk <= 0;
      ch <= 0;
    end else if (tick_i) begin
      if (tk >= (slow_i ? 7 : 1)) begin
        tk     <= 0;
        done_o <= 1'b1;
        last_o <= (ch == NCH - 1);
        ch     <= (ch == NCH - 1) ? 0 : ch + 1;
      end else begin
        tk <= tk + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- adcrc_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface adcrc_if;
  logic        wr_en;
  logic [15:0] wr_idx;
  logic [15:0] wr_data;
  logic [1:0]  wr_strb;
  logic        rd_en;
  logic [15:0] rd_idx;
  logic [15:0] rd_data;
  logic [3:0]  ratio;
  logic        restart;
  logic        tick;
  modport slv  (output wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx, input rd_data);
  modport regs (input wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx, tick,
                output rd_data, ratio, restart);
  modport div  (input ratio, restart, output tick);
endinterface
`default_nettype wire

// ---- adcrc_params.svh ----
`ifndef ADCRC_PARAMS_SVH
`define ADCRC_PARAMS_SVH
// bus address width and register indices (byte address = index * 4)
`define ADCRC_AW      18
`define ADCRC_IDX_TRG 16'h5382
`define ADCRC_IDX_CTL 16'h5384
`define ADCRC_IDX_CLK 16'h5386
`define ADCRC_IDX_IST 16'h5388
`define ADCRC_IDX_IMK 16'h538A
// control/status field positions
`define ADCRC_CTL_EN  0
`define ADCRC_CTL_RUN 1
`define ADCRC_CTL_CIE 4
`define ADCRC_CTL_OIE 5
`define ADCRC_CTL_CF  8
`define ADCRC_CTL_OW  9
`define ADCRC_CTL_BSY 10
// trigger/mode field positions and trigger codes
`define ADCRC_TRG_MODE 6
`define ADCRC_TRG_TS   4
`define ADCRC_TS_SW    2'h0
`define ADCRC_TS_TMR   2'h1
`define ADCRC_TS_PIN   2'h3
// event status bits
`define ADCRC_IST_CMP 0
`define ADCRC_IST_OVR 1
// reset values and codes
`define ADCRC_RATIO_RST 4'h0
`define ADCRC_RATIO_RSV 4'hF
`define ADCRC_IMK_RST   2'h3
`define ADCRC_RESP_OK   2'h0
`define ADCRC_RESP_ERR  2'h2
`endif

// ---- adcrc_pkg.sv ----
`default_nettype none
package adcrc_pkg;
  `include "adcrc_params.svh"

  typedef enum logic {ST_IDLE, ST_RUN} adcrc_state_t;

  // true when a byte address hits one of the mapped registers
  function automatic logic adcrc_hit(input logic [`ADCRC_AW-1:0] a);
    logic [15:0] idx;
    idx = a[`ADCRC_AW-1:2];
    return (a[1:0] == 2'h0) &&
           (idx == `ADCRC_IDX_TRG || idx == `ADCRC_IDX_CTL ||
            idx == `ADCRC_IDX_CLK || idx == `ADCRC_IDX_IST ||
            idx == `ADCRC_IDX_IMK);
  endfunction
endpackage
`default_nettype wire

// ---- adcrc_top.sv ----
// Behaviour
// - overrun interrupt forwarded only when its enable set
// - completion interrupt forwarded only when enable set
// - software writing run bit starts conversion
// - hardware trigger sets run bit itself
// - run bit reads one while converting
// - one-time mode clears run after range done
// - continuous mode stops when software writes zero
// - converter disabled ignores every trigger source
// - enable bit set makes triggers accepted
// - clearing enable never aborts running conversion
// - clock divided by two up to 32768
// - mode bit picks continuous or one-time
// - busy mirrors run bit: set at trigger, cleared when the run ends
// - completion with flag set overwrites, flags overrun
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "adcrc_params.svh"
module adcrc_top
  import adcrc_pkg::*;
#(
  parameter int DIV_W = 15
) (
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  input  wire logic [`ADCRC_AW-1:0] s_axi_awaddr_i,
  input  wire logic                 s_axi_awvalid_i,
  output logic                      s_axi_awready_o,
  input  wire logic [31:0]          s_axi_wdata_i,
  input  wire logic [3:0]           s_axi_wstrb_i,
  input  wire logic                 s_axi_wvalid_i,
  output logic                      s_axi_wready_o,
  output logic [1:0]                s_axi_bresp_o,
  output logic                      s_axi_bvalid_o,
  input  wire logic                 s_axi_bready_i,
  input  wire logic [`ADCRC_AW-1:0] s_axi_araddr_i,
  input  wire logic                 s_axi_arvalid_i,
  output logic                      s_axi_arready_o,
  output logic [31:0]               s_axi_rdata_o,
  output logic [1:0]                s_axi_rresp_o,
  output logic                      s_axi_rvalid_o,
  input  wire logic                 s_axi_rready_i,
  input  wire logic                 timer_uf_i,
  input  wire logic                 trig_pin_n_i,
  input  wire logic                 chan_done_i,
  input  wire logic                 range_last_i,
  input  wire logic                 result_read_i,
  output logic                      conv_run_o,
  output logic                      conv_start_o,
  output logic                      conv_clk_en_o,
  output logic                      irq_o
);
  adcrc_if rif ();

  // *************************************************
  // register bus slave and conversion clock divider
  // *************************************************
  adcrc_axil u_axil (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .awaddr_i  (s_axi_awaddr_i),
    .awvalid_i (s_axi_awvalid_i),
    .awready_o (s_axi_awready_o),
    .wdata_i   (s_axi_wdata_i),
    .wstrb_i   (s_axi_wstrb_i),
    .wvalid_i  (s_axi_wvalid_i),
    .wready_o  (s_axi_wready_o),
    .bresp_o   (s_axi_bresp_o),
    .bvalid_o  (s_axi_bvalid_o),
    .bready_i  (s_axi_bready_i),
    .araddr_i  (s_axi_araddr_i),
    .arvalid_i (s_axi_arvalid_i),
    .arready_o (s_axi_arready_o),
    .rdata_o   (s_axi_rdata_o),
    .rresp_o   (s_axi_rresp_o),
    .rvalid_o  (s_axi_rvalid_o),
    .rready_i  (s_axi_rready_i),
    .rif       (rif.slv)
  );

  adcrc_clkdiv #(
    .CW (DIV_W)
  ) u_div (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .dif    (rif.div)
  );

  // *************************************************
  // software-visible state
  // *************************************************
  adcrc_state_t state_q, state_d;
  logic         en_q, en_d, cie_q, cie_d, oie_q, oie_d, mode_q, mode_d;
  logic [1:0]   ts_q, ts_d, imk_q, imk_d, ist_q, ist_d;
  logic [3:0]   ratio_q, ratio_d;
  logic         cf_q, cf_d, ow_q, ow_d;
  logic         start_q, start_d, irq_q, irq_d, run_q, run_d;
  logic         pin1_q, pin2_q, pin3_q;
  logic         wr_trg, wr_ctl, wr_clk, wr_imk, wr_ctl_hi;
  logic         run, sw_trig, hw_trig, accept, stop_wr, done, last_done;

  assign run       = (state_q == ST_RUN);
  assign wr_trg    = rif.wr_en && rif.wr_strb[0] && rif.wr_idx == `ADCRC_IDX_TRG;
  assign wr_ctl    = rif.wr_en && rif.wr_strb[0] && rif.wr_idx == `ADCRC_IDX_CTL;
  assign wr_ctl_hi = rif.wr_en && rif.wr_strb[1] && rif.wr_idx == `ADCRC_IDX_CTL;
  assign wr_clk    = rif.wr_en && rif.wr_strb[0] && rif.wr_idx == `ADCRC_IDX_CLK;
  assign wr_imk    = rif.wr_en && rif.wr_strb[0] && rif.wr_idx == `ADCRC_IDX_IMK;

  // *************************************************
  // trigger selection and acceptance
  // *************************************************
  assign sw_trig = wr_ctl && rif.wr_data[`ADCRC_CTL_RUN] && ts_q == `ADCRC_TS_SW;
  assign hw_trig = (ts_q == `ADCRC_TS_TMR && timer_uf_i) ||
                   (ts_q == `ADCRC_TS_PIN && pin3_q && !pin2_q);
  assign accept  = !run && en_q && (sw_trig || hw_trig);
  assign stop_wr = run && wr_ctl && !rif.wr_data[`ADCRC_CTL_RUN];
  assign done      = run && chan_done_i;
  assign last_done = done && range_last_i && !mode_q;

  // run sequencer; enable only gates the start, never the run
  always_comb begin
    state_d = state_q;
    start_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          state_d = ST_RUN;
          start_d = 1'b1;
        end
      end
      ST_RUN: begin
        if (stop_wr || last_done) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    run_d = (state_d == ST_RUN);
  end

  // control fields written by software
  always_comb begin
    en_d = en_q; cie_d = cie_q; oie_d = oie_q;
    mode_d = mode_q; ts_d = ts_q; ratio_d = ratio_q; imk_d = imk_q;
    if (wr_ctl) begin
      en_d  = rif.wr_data[`ADCRC_CTL_EN];
      cie_d = rif.wr_data[`ADCRC_CTL_CIE];
      oie_d = rif.wr_data[`ADCRC_CTL_OIE];
    end
    if (wr_trg) begin
      mode_d = rif.wr_data[`ADCRC_TRG_MODE];
      ts_d   = rif.wr_data[`ADCRC_TRG_TS +: 2];
    end
    if (wr_clk) begin
      ratio_d = rif.wr_data[3:0];
    end
    if (wr_imk) begin
      imk_d = rif.wr_data[1:0];
    end
  end

  // completion and overrun flags, set beats clear
  always_comb begin
    cf_d = cf_q;
    ow_d = ow_q;
    if (result_read_i) begin
      cf_d = 1'b0;
    end
    if (wr_ctl_hi && rif.wr_data[`ADCRC_CTL_OW]) begin
      ow_d = 1'b0;
    end
    if (done) begin
      cf_d = 1'b1;
      if (cf_q) begin
        ow_d = 1'b1;
      end
    end
  end

  // sticky event status, read clears it, new events win
  always_comb begin
    ist_d = ist_q;
    if (rif.rd_en && rif.rd_idx == `ADCRC_IDX_IST) begin
      ist_d = 2'h0;
    end
    if (done) begin
      ist_d[`ADCRC_IST_CMP] = 1'b1;
    end
    if (done && cf_q) begin
      ist_d[`ADCRC_IST_OVR] = 1'b1;
    end
    irq_d = |(ist_q & imk_q & {oie_q, cie_q});
  end

  // register everything, pin passes two flops before its edge detector
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= ST_IDLE;
      en_q    <= 1'b0;
      cie_q   <= 1'b0;
      oie_q   <= 1'b0;
      mode_q  <= 1'b0;
      ts_q    <= `ADCRC_TS_SW;
      ratio_q <= `ADCRC_RATIO_RST;
      imk_q   <= `ADCRC_IMK_RST;
      ist_q   <= 2'h0;
      cf_q    <= 1'b0;
      ow_q    <= 1'b0;
      start_q <= 1'b0;
      run_q   <= 1'b0;
      irq_q   <= 1'b0;
      pin1_q  <= 1'b1;
      pin2_q  <= 1'b1;
      pin3_q  <= 1'b1;
    end else begin
      state_q <= state_d;
      en_q    <= en_d;
      cie_q   <= cie_d;
      oie_q   <= oie_d;
      mode_q  <= mode_d;
      ts_q    <= ts_d;
      ratio_q <= ratio_d;
      imk_q   <= imk_d;
      ist_q   <= ist_d;
      cf_q    <= cf_d;
      ow_q    <= ow_d;
      start_q <= start_d;
      run_q   <= run_d;
      irq_q   <= irq_d;
      pin1_q  <= trig_pin_n_i;
      pin2_q  <= pin1_q;
      pin3_q  <= pin2_q;
    end
  end

  assign rif.ratio   = ratio_q;
  assign rif.restart = wr_clk;

  // *************************************************
  // read data
  // *************************************************
  always_comb begin
    rif.rd_data = 16'h0000;
    case (rif.rd_idx)
      `ADCRC_IDX_TRG: begin
        rif.rd_data[`ADCRC_TRG_MODE]   = mode_q;
        rif.rd_data[`ADCRC_TRG_TS +: 2] = ts_q;
      end
      `ADCRC_IDX_CTL: begin
        rif.rd_data[`ADCRC_CTL_EN]  = en_q;
        rif.rd_data[`ADCRC_CTL_RUN] = run;
        rif.rd_data[`ADCRC_CTL_CIE] = cie_q;
        rif.rd_data[`ADCRC_CTL_OIE] = oie_q;
        rif.rd_data[`ADCRC_CTL_CF]  = cf_q;
        rif.rd_data[`ADCRC_CTL_OW]  = ow_q;
        rif.rd_data[`ADCRC_CTL_BSY] = run;
      end
      `ADCRC_IDX_CLK: rif.rd_data[3:0] = ratio_q;
      `ADCRC_IDX_IST: rif.rd_data[1:0] = ist_q;
      `ADCRC_IDX_IMK: rif.rd_data[1:0] = imk_q;
      default: rif.rd_data = 16'h0000;
    endcase
  end

  assign conv_run_o    = run_q;
  assign conv_start_o  = start_q;
  assign conv_clk_en_o = rif.tick;
  assign irq_o         = irq_q;

  // *************************************************
  // checks
  // *************************************************
  property p_irq_off;
    @(posedge clk_i) disable iff (srst_i)
      (!cie_q && !oie_q) |=> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with enables off");

  property p_sw_start;
    @(posedge clk_i) disable iff (srst_i)
      (!run && en_q && sw_trig) |=> (conv_run_o && conv_start_o) ##1 !conv_start_o;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start lost");

  property p_tmr_start;
    @(posedge clk_i) disable iff (srst_i)
      (!run && en_q && ts_q == `ADCRC_TS_TMR && timer_uf_i) |=> conv_run_o;
  endproperty
  a_tmr_start: assert property (p_tmr_start) else $error("timer start lost");

  property p_disabled;
    @(posedge clk_i) disable iff (srst_i)
      (!run && !en_q) |=> !conv_run_o;
  endproperty
  a_disabled: assert property (p_disabled) else $error("start while disabled");

  property p_keep_run;
    @(posedge clk_i) disable iff (srst_i)
      (run && !stop_wr && !last_done) |=> conv_run_o;
  endproperty
  a_keep_run: assert property (p_keep_run) else $error("run dropped");

  property p_one_time;
    @(posedge clk_i) disable iff (srst_i)
      last_done |=> !conv_run_o;
  endproperty
  a_one_time: assert property (p_one_time) else $error("one-time run not ended");

  property p_stop;
    @(posedge clk_i) disable iff (srst_i)
      stop_wr |=> !conv_run_o ##1 (!conv_run_o || $past(accept));
  endproperty
  a_stop: assert property (p_stop) else $error("stop write ignored");

  property p_overrun;
    @(posedge clk_i) disable iff (srst_i)
      (done && cf_q) |=> (ow_q && cf_q && ist_q[`ADCRC_IST_OVR]);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");
endmodule
`default_nettype wire

// ---- test_adc_run_control_and_clock_divider.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "adcrc_params.svh"
module test_adc_run_control_and_clock_divider
  import adcrc_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  localparam logic [17:0] A_TRG = {`ADCRC_IDX_TRG, 2'h0};
  localparam logic [17:0] A_CTL = {`ADCRC_IDX_CTL, 2'h0};
  localparam logic [17:0] A_CLK = {`ADCRC_IDX_CLK, 2'h0};
  localparam logic [17:0] A_IST = {`ADCRC_IDX_IST, 2'h0};
  localparam logic [17:0] A_IMK = {`ADCRC_IDX_IMK, 2'h0};
  localparam logic [17:0] A_BAD = 18'h14E40;
  localparam logic [1:0]  OK    = `ADCRC_RESP_OK;
  localparam logic [1:0]  ERR   = `ADCRC_RESP_ERR;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [17:0] awaddr = '0;
  logic [17:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = '0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        timer_uf = 1'b0;
  logic        trig_pin_n = 1'b1;
  logic        result_read = 1'b0;
  logic        slow = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        chan_done, range_last, conv_run, conv_start, conv_clk_en, irq;
  int          err_count = 0;
  int          comparisons = 0;
  int          starts = 0;
  int          n;

  // 10 MHz clock
  always #50 clk_i = ~clk_i;

  // count accepted triggers seen on the start pulse
  always @(posedge clk_i) begin
    if (conv_start === 1'b1) starts <= starts + 1;
  end

  adcrc_top dut_u (.clk_i(clk_i), .srst_i(srst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .timer_uf_i(timer_uf), .trig_pin_n_i(trig_pin_n),
    .chan_done_i(chan_done), .range_last_i(range_last), .result_read_i(result_read),
    .conv_run_o(conv_run), .conv_start_o(conv_start), .conv_clk_en_o(conv_clk_en),
    .irq_o(irq));

  adcrc_core_model #(.NCH(2)) core_u (.clk_i(clk_i), .srst_i(srst_i), .run_i(conv_run),
    .start_i(conv_start), .tick_i(conv_clk_en), .slow_i(slow), .done_o(chan_done),
    .last_o(range_last));

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [17:0] a, input logic [15:0] d, input logic [1:0] er);
    logic aw_d;
    logic w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge clk_i);
      aw_d = aw_d | awready;
      w_d = w_d | wready;
      if (aw_d) awvalid <= 1'b0;
      if (w_d) wvalid <= 1'b0;
    end
    while (!bvalid) @(posedge clk_i);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask

  task automatic rd(input logic [17:0] a, input logic [15:0] exp, input logic [1:0] er);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (!rvalid);
    rready <= 1'b0;
    chk(rdata, {16'h0000, exp});
    chk(32'(rresp), 32'(er));
  endtask

  task automatic wait_run(input logic lvl, input int lim);
    int i;
    i = 0;
    while (conv_run !== lvl && i < lim) begin
      @(posedge clk_i);
      i++;
    end
    #1;
    chk(32'(conv_run), 32'(lvl));
  endtask

  // settings change only with the converter disabled
  task automatic set_mode(input logic [15:0] m);
    wr(A_CTL, 16'h0000, OK);
    wr(A_TRG, m, OK);
  endtask

  task automatic give_verdict;
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  // watchdog against a hung handshake
  initial begin
    #(100 * 50000);
    err_count++;
    give_verdict;
  end

  // main sequence
  initial begin
    logic [17:0] at [5];
    logic [15:0] et [5];
    at = '{A_TRG, A_CTL, A_CLK, A_IST, A_IMK};
    et = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0003};
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    step(2);
    for (int i = 0; i < 5; i++) rd(at[i], et[i], OK);
    rd(A_BAD, 16'h0000, ERR);
    wr(A_BAD, 16'hFFFF, ERR);
    // tick spacing for ratio codes 0 to 5, then no ticks with the reserved code
    for (int c = 0; c < 6; c++) begin
      wr(A_CLK, 16'(c), OK);
      rd(A_CLK, 16'(c), OK);
      n = 0;
      while (!conv_clk_en && n < 200) begin
        @(posedge clk_i);
        n++;
      end
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (!conv_clk_en && n < 200);
      chk(32'(n), 32'(1) << (c + 1));
    end
    wr(A_CLK, 16'h000F, OK);
    step(4);
    n = 0;
    repeat (100) begin
      @(posedge clk_i);
      if (conv_clk_en) n++;
    end
    chk(32'(n), 32'h0);
    wr(A_CLK, 16'h0000, OK);
    // triggers while disabled, then timer and pin triggers
    set_mode(16'h0010);
    wr(A_CTL, 16'h0002, OK);
    @(posedge clk_i) timer_uf <= 1'b1;
    @(posedge clk_i) timer_uf <= 1'b0;
    step(4);
    chk(32'(conv_run), 32'h0);
    wr(A_CTL, 16'h0001, OK);
    @(posedge clk_i) timer_uf <= 1'b1;
    @(posedge clk_i) timer_uf <= 1'b0;
    wait_run(1'b1, 4);
    wait_run(1'b0, 100);
    set_mode(16'h0030);
    wr(A_CTL, 16'h0001, OK);
    @(posedge clk_i) trig_pin_n <= 1'b0;
    wait_run(1'b1, 8);
    @(posedge clk_i) trig_pin_n <= 1'b1;
    wait_run(1'b0, 100);
    chk(32'(irq), 32'h0);
    rd(A_CTL, 16'h0301, OK);
    rd(A_IST, 16'h0003, OK);
    wr(A_CTL, 16'h0200, OK);
    rd(A_CTL, 16'h0100, OK);
    @(posedge clk_i) result_read <= 1'b1;
    @(posedge clk_i) result_read <= 1'b0;
    rd(A_CTL, 16'h0000, OK);
    // software start, completion and overrun interrupts, mask
    set_mode(16'h0000);
    slow <= 1'b1;
    wr(A_CTL, 16'h0011, OK);
    wr(A_CTL, 16'h0013, OK);
    rd(A_CTL, 16'h0413, OK);
    wait_run(1'b0, 300);
    step(1);
    chk(32'(irq), 32'h1);
    rd(A_IST, 16'h0003, OK);
    step(2);
    chk(32'(irq), 32'h0);
    wr(A_CTL, 16'h0023, OK);
    wait_run(1'b0, 300);
    step(1);
    chk(32'(irq), 32'h1);
    rd(A_IST, 16'h0003, OK);
    wr(A_IMK, 16'h0000, OK);
    wr(A_CTL, 16'h0033, OK);
    wait_run(1'b0, 300);
    step(1);
    chk(32'(irq), 32'h0);
    rd(A_IST, 16'h0003, OK);
    wr(A_IMK, 16'h0003, OK);
    rd(A_IMK, 16'h0003, OK);
    slow <= 1'b0;
    // continuous run, disable without abort, software stop
    set_mode(16'h0040);
    wr(A_CTL, 16'h0001, OK);
    wr(A_CTL, 16'h0003, OK);
    step(60);
    chk(32'(conv_run), 32'h1);
    wr(A_CTL, 16'h0002, OK);
    step(30);
    chk(32'(conv_run), 32'h1);
    wr(A_CTL, 16'h0000, OK);
    wait_run(1'b0, 2);
    wr(A_CTL, 16'h0002, OK);
    step(4);
    chk(32'(conv_run), 32'h0);
    chk(32'(starts), 32'd6);
    give_verdict;
  end
endmodule
`default_nettype wire
